// *** shared/dmc_regs.vh ***
// register offsets, field positions, reset values and timing counts of the dma channel control
`ifndef DMC_REGS_VH
`define DMC_REGS_VH
`define DMC_ADDR_MODE0 20'hFFFBA
`define DMC_ADDR_MODE1 20'hFFFBB
`define DMC_ADDR_RUN0 20'hFFFBC
`define DMC_ADDR_RUN1 20'hFFFBD
`define DMC_MODE_RESET 8'h00
`define DMC_RUN_RESET 8'h00
`define DMC_BIT_TRIG 7
`define DMC_BIT_DIR 6
`define DMC_BIT_SIZE 5
`define DMC_BIT_HOLD 4
`define DMC_BIT_EN 7
`define DMC_BIT_ACT 0
`define DMC_SRC_NONE 4'h0
`define DMC_SRC_TM0 4'h2
`define DMC_SRC_TM1 4'h3
`define DMC_SRC_TM4 4'h4
`define DMC_SRC_TM5 4'h5
`define DMC_SRC_S0TX 4'h6
`define DMC_SRC_S0RX 4'h7
`define DMC_SRC_S1TX 4'h8
`define DMC_SRC_S1RX 4'h9
`define DMC_SRC_S3TX 4'hA
`define DMC_SRC_S3RX 4'hB
`define DMC_SRC_ADC 4'hC
`define DMC_HOLD_LATENCY 2
`define DMC_STOP_LATENCY 2
`endif

// *** logic/dmc_channel.v ***
// one dma channel: mode and run control, trigger selection, transfer sequencing
`timescale 1ns/10ps
`include "dmc_regs.vh"
module dmc_channel
(
	input wire clock,
	input wire srst,
	input wire mode_wr,
	input wire run_wr,
	input wire [7:0] wdata,
	input wire [7:0] wmask,
	input wire [10:0] irq_vec,
	input wire [9:0] count_load,
	input wire count_wr,
	input wire [15:0] ram_load,
	input wire ram_wr,
	input wire [7:0] periph_addr,
	output wire [7:0] mode_rd,
	output wire [7:0] run_rd,
	output reg [9:0] transfer_counter,
	output reg [15:0] ram_address_reg,
	output reg xfer_busy,
	output reg xfer_phase,
	output reg direction,
	output reg halfword,
	output reg [15:0] xfer_ram_addr,
	output reg [7:0] xfer_periph_addr,
	output reg completion_irq
);
	reg direction_sel;
	reg size_sel;
	reg hold_pending;
	reg [3:0] trigger_source;
	reg channel_enable;
	reg transfer_active;
	reg pending;
	reg [1:0] hold_pipe;
	reg hw_trig;
	wire [7:0] next_mode;
	wire [7:0] next_run;
	wire [7:0] mode_now;
	wire sw_trig;
	wire hold_eff;
	wire go;
	wire last;
	assign mode_now = {1'b0, direction_sel, size_sel, hold_pending, trigger_source};
	assign next_mode = (mode_now & ~wmask) | (wdata & wmask);
	assign next_run = (run_rd & ~wmask) | (wdata & wmask);
	assign mode_rd = {1'b0, direction_sel, size_sel, hold_pending, trigger_source};
	assign run_rd = {channel_enable, 6'h00, transfer_active};
	assign sw_trig = mode_wr & wmask[`DMC_BIT_TRIG] & wdata[`DMC_BIT_TRIG] & channel_enable;
	assign hold_eff = hold_pending & hold_pipe[1];
	assign go = pending & ~hold_eff & channel_enable & transfer_active & ~xfer_busy;
	assign last = transfer_counter == 10'h001;
	always @*
	begin
		case (trigger_source)
			`DMC_SRC_TM0: hw_trig = irq_vec[0];
			`DMC_SRC_TM1: hw_trig = irq_vec[1];
			`DMC_SRC_TM4: hw_trig = irq_vec[2];
			`DMC_SRC_TM5: hw_trig = irq_vec[3];
			`DMC_SRC_S0TX: hw_trig = irq_vec[4];
			`DMC_SRC_S0RX: hw_trig = irq_vec[5];
			`DMC_SRC_S1TX: hw_trig = irq_vec[6];
			`DMC_SRC_S1RX: hw_trig = irq_vec[7];
			`DMC_SRC_S3TX: hw_trig = irq_vec[8];
			`DMC_SRC_S3RX: hw_trig = irq_vec[9];
			`DMC_SRC_ADC: hw_trig = irq_vec[10];
			default: hw_trig = 1'b0;
		endcase
	end
	always @(posedge clock)
	begin
		if (srst)
		begin
			direction_sel <= 1'b0;
			size_sel <= 1'b0;
			hold_pending <= 1'b0;
			trigger_source <= 4'h0;
			channel_enable <= 1'b0;
			transfer_active <= 1'b0;
			pending <= 1'b0;
			hold_pipe <= 2'h0;
			transfer_counter <= 10'h000;
			ram_address_reg <= 16'h0000;
			xfer_busy <= 1'b0;
			xfer_phase <= 1'b0;
			direction <= 1'b0;
			halfword <= 1'b0;
			xfer_ram_addr <= 16'h0000;
			xfer_periph_addr <= 8'h00;
			completion_irq <= 1'b0;
		end
		else
		begin
			completion_irq <= 1'b0;
			hold_pipe <= {hold_pipe[0], hold_pending};
			if (mode_wr)
			begin
				direction_sel <= next_mode[`DMC_BIT_DIR];
				size_sel <= next_mode[`DMC_BIT_SIZE];
				hold_pending <= next_mode[`DMC_BIT_HOLD];
				trigger_source <= next_mode[3:0];
			end
			if (run_wr)
				channel_enable <= next_run[`DMC_BIT_EN];
			if (count_wr & ~transfer_active)
				transfer_counter <= count_load;
			if (ram_wr & ~transfer_active)
				ram_address_reg <= ram_load;
			if (channel_enable & (sw_trig | (transfer_active & hw_trig)))
				pending <= 1'b1;
			else if (go | ~channel_enable | ~transfer_active)
				pending <= 1'b0;
			if (go)
			begin
				xfer_busy <= 1'b1;
				xfer_phase <= 1'b0;
				direction <= direction_sel;
				halfword <= size_sel;
				xfer_ram_addr <= size_sel ? {ram_address_reg[15:1], 1'b0} : ram_address_reg;
				xfer_periph_addr <= size_sel ? {periph_addr[7:1], 1'b0} : periph_addr;
			end
			else if (xfer_busy & ~xfer_phase)
				xfer_phase <= 1'b1;
			else if (xfer_busy)
			begin
				xfer_busy <= 1'b0;
				xfer_phase <= 1'b0;
				transfer_counter <= transfer_counter - 10'h001;
				ram_address_reg <= ram_address_reg + (halfword ? 16'h0002 : 16'h0001);
			end
			if (xfer_busy & xfer_phase & last & transfer_active)
			begin
				transfer_active <= 1'b0;
				completion_irq <= 1'b1;
			end
			else if (run_wr)
				transfer_active <= next_run[`DMC_BIT_ACT] & (channel_enable | next_run[`DMC_BIT_EN]);
		end
	end
endmodule

// *** logic/dmc_top.v ***
// two-channel dma mode and run control with its register port
`timescale 1ns/10ps
`include "dmc_regs.vh"
module dmc_top
(
	input wire clock,
	input wire srst,
	input wire [19:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_wmask,
	output reg [7:0] reg_rdata,
	input wire timer0_irq,
	input wire timer1_irq,
	input wire timer4_irq,
	input wire timer5_irq,
	input wire serial0_tx_end_irq,
	input wire serial0_rx_end_irq,
	input wire serial1_tx_end_irq,
	input wire serial1_rx_end_irq,
	input wire serial3_tx_end_irq,
	input wire serial3_rx_end_irq,
	input wire adc_end_irq,
	input wire [9:0] count_load0,
	input wire count_wr0,
	input wire [15:0] ram_load0,
	input wire ram_wr0,
	input wire [7:0] periph_address_reg0,
	input wire [9:0] count_load1,
	input wire count_wr1,
	input wire [15:0] ram_load1,
	input wire ram_wr1,
	input wire [7:0] periph_address_reg1,
	output wire [9:0] transfer_counter0,
	output wire [15:0] ram_address_reg0,
	output wire [9:0] transfer_counter1,
	output wire [15:0] ram_address_reg1,
	output wire cpu_stall,
	output wire xfer_busy0,
	output wire xfer_phase0,
	output wire direction0,
	output wire halfword0,
	output wire [15:0] xfer_ram_addr0,
	output wire [7:0] xfer_periph_addr0,
	output wire xfer_busy1,
	output wire xfer_phase1,
	output wire direction1,
	output wire halfword1,
	output wire [15:0] xfer_ram_addr1,
	output wire [7:0] xfer_periph_addr1,
	output wire completion_irq0,
	output wire completion_irq1
);
	wire [10:0] irq_vec;
	wire [7:0] mode_rd0;
	wire [7:0] mode_rd1;
	wire [7:0] run_rd0;
	wire [7:0] run_rd1;
	assign irq_vec = {adc_end_irq, serial3_rx_end_irq, serial3_tx_end_irq, serial1_rx_end_irq,
		serial1_tx_end_irq, serial0_rx_end_irq, serial0_tx_end_irq, timer5_irq, timer4_irq, timer1_irq, timer0_irq};
	assign cpu_stall = xfer_busy0 | xfer_busy1;
	always @(posedge clock)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`DMC_ADDR_MODE0: reg_rdata <= mode_rd0;
				`DMC_ADDR_MODE1: reg_rdata <= mode_rd1;
				`DMC_ADDR_RUN0: reg_rdata <= run_rd0;
				`DMC_ADDR_RUN1: reg_rdata <= run_rd1;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end
	dmc_channel u_ch0
	(
		.clock(clock),
		.srst(srst),
		.mode_wr(reg_wr & (reg_addr == `DMC_ADDR_MODE0)),
		.run_wr(reg_wr & (reg_addr == `DMC_ADDR_RUN0)),
		.wdata(reg_wdata),
		.wmask(reg_wmask),
		.irq_vec(irq_vec),
		.count_load(count_load0),
		.count_wr(count_wr0),
		.ram_load(ram_load0),
		.ram_wr(ram_wr0),
		.periph_addr(periph_address_reg0),
		.mode_rd(mode_rd0),
		.run_rd(run_rd0),
		.transfer_counter(transfer_counter0),
		.ram_address_reg(ram_address_reg0),
		.xfer_busy(xfer_busy0),
		.xfer_phase(xfer_phase0),
		.direction(direction0),
		.halfword(halfword0),
		.xfer_ram_addr(xfer_ram_addr0),
		.xfer_periph_addr(xfer_periph_addr0),
		.completion_irq(completion_irq0)
	);
	dmc_channel u_ch1
	(
		.clock(clock),
		.srst(srst),
		.mode_wr(reg_wr & (reg_addr == `DMC_ADDR_MODE1)),
		.run_wr(reg_wr & (reg_addr == `DMC_ADDR_RUN1)),
		.wdata(reg_wdata),
		.wmask(reg_wmask),
		.irq_vec(irq_vec),
		.count_load(count_load1),
		.count_wr(count_wr1),
		.ram_load(ram_load1),
		.ram_wr(ram_wr1),
		.periph_addr(periph_address_reg1),
		.mode_rd(mode_rd1),
		.run_rd(run_rd1),
		.transfer_counter(transfer_counter1),
		.ram_address_reg(ram_address_reg1),
		.xfer_busy(xfer_busy1),
		.xfer_phase(xfer_phase1),
		.direction(direction1),
		.halfword(halfword1),
		.xfer_ram_addr(xfer_ram_addr1),
		.xfer_periph_addr(xfer_periph_addr1),
		.completion_irq(completion_irq1)
	);
endmodule

// *** testbench/dmc_top_asserts.sv ***
// concurrent checks on the dma register port and channel 0 transfer timing
`timescale 1ns/10ps
module dmc_chk
(
	input wire clock,
	input wire srst,
	input wire [19:0] reg_addr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire cpu_stall,
	input wire xfer_busy0,
	input wire xfer_busy1,
	input wire xfer_phase0,
	input wire halfword0,
	input wire [9:0] transfer_counter0,
	input wire [15:0] ram_address_reg0,
	input wire completion_irq0
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	property p_busy_len; $rose(xfer_busy0) |=> xfer_busy0 ##1 !xfer_busy0; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy not two cycles");
	property p_phase; $rose(xfer_busy0) |-> !xfer_phase0 ##1 xfer_phase0; endproperty
	a_phase: assert property (p_phase) else $error("phase order wrong");
	property p_stall; cpu_stall == (xfer_busy0 | xfer_busy1); endproperty
	a_stall: assert property (p_stall) else $error("stall not tied to busy");
	property p_count; $fell(xfer_busy0) |-> transfer_counter0 == $past(transfer_counter0) - 10'h001; endproperty
	a_count: assert property (p_count) else $error("counter step wrong");
	property p_addr; $fell(xfer_busy0) |-> ram_address_reg0 == $past(ram_address_reg0) + (halfword0 ? 16'h0002 : 16'h0001); endproperty
	a_addr: assert property (p_addr) else $error("ram address step wrong");
	property p_irq; completion_irq0 |-> ($fell(xfer_busy0) && transfer_counter0 == 10'h000) ##1 !completion_irq0; endproperty
	a_irq: assert property (p_irq) else $error("completion pulse wrong");
	property p_mode_rd; reg_rd && reg_addr == 20'hFFFBA |=> !reg_rdata[7]; endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("trigger bit read as one");
	property p_run_rd; reg_rd && reg_addr == 20'hFFFBC |=> reg_rdata[6:1] == 6'h00; endproperty
	a_run_rd: assert property (p_run_rd) else $error("unused run bits set");
	c_done: cover property (completion_irq0);
	c_half: cover property ($rose(xfer_busy0) && halfword0);
	c_byte: cover property ($rose(xfer_busy0) && !halfword0);
endmodule
bind dmc_top dmc_chk u_chk (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cpu_stall(cpu_stall), .xfer_busy0(xfer_busy0), .xfer_busy1(xfer_busy1), .xfer_phase0(xfer_phase0),
	.halfword0(halfword0), .transfer_counter0(transfer_counter0), .ram_address_reg0(ram_address_reg0),
	.completion_irq0(completion_irq0));

// *** testbench/dmc_irq_src.sv ***
// peripheral interrupt sources: the selected line pulses one cycle per request
`timescale 1ns/10ps
module dmc_irq_src
(
	input wire clock,
	input wire go,
	input wire [3:0] idx,
	output reg [10:0] irq
);
	initial irq = 11'h000;
	always @(negedge clock)
		irq <= go ? (11'h001 << idx) : 11'h000;
endmodule

// *** testbench/dmc_top_tb.sv ***
// self-checking bench for the two-channel dma mode and run control
`timescale 1ns/10ps
`include "dmc_regs.vh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, s); end end
module dmc_top_tb;
	reg clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, go = 0, ld_wr = 0, hit = 0;
	reg [19:0] reg_addr = 20'h00000;
	reg [7:0] reg_wdata = 8'h00, reg_wmask = 8'h00;
	reg [9:0] count_load0 = 10'h000;
	reg [15:0] ram_load0 = 16'h0000;
	reg [3:0] idx = 4'h0;
	int bad_count = 0, comparisons = 0;
	int irq_cnt = 0, irq_base = 0, irq1_cnt = 0;
	wire [10:0] irq;
	wire [7:0] reg_rdata;
	wire [9:0] transfer_counter0;
	wire [15:0] ram_address_reg0;
	wire xfer_busy0, xfer_busy1, direction0, halfword0, completion_irq0;
	wire [9:0] transfer_counter1;
	wire [15:0] ram_address_reg1, xfer_ram_addr0;
	wire [7:0] xfer_periph_addr0;
	wire cpu_stall, direction1, halfword1, completion_irq1;
	dmc_irq_src src (.clock, .go, .idx, .irq);
	dmc_top dut (.clock, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_wmask, .reg_rdata,
		.timer0_irq(irq[0]), .timer1_irq(irq[1]), .timer4_irq(irq[2]), .timer5_irq(irq[3]),
		.serial0_tx_end_irq(irq[4]), .serial0_rx_end_irq(irq[5]), .serial1_tx_end_irq(irq[6]),
		.serial1_rx_end_irq(irq[7]), .serial3_tx_end_irq(irq[8]), .serial3_rx_end_irq(irq[9]), .adc_end_irq(irq[10]),
		.count_load0, .count_wr0(ld_wr), .ram_load0, .ram_wr0(ld_wr), .periph_address_reg0(8'h11),
		.count_load1(count_load0), .count_wr1(ld_wr), .ram_load1(ram_load0), .ram_wr1(ld_wr), .periph_address_reg1(8'h20),
		.transfer_counter0, .ram_address_reg0, .transfer_counter1, .ram_address_reg1, .cpu_stall,
		.xfer_busy0, .xfer_phase0(), .direction0, .halfword0, .xfer_ram_addr0, .xfer_periph_addr0,
		.xfer_busy1, .xfer_phase1(), .direction1, .halfword1, .xfer_ram_addr1(), .xfer_periph_addr1(),
		.completion_irq0, .completion_irq1);
	initial forever #5 clock = ~clock;
	always @(posedge clock) irq_cnt <= irq_cnt + completion_irq0;
	always @(posedge clock) irq1_cnt <= irq1_cnt + completion_irq1;
	task wr(input [19:0] a, input [7:0] d, input [7:0] m);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wmask = m;
		reg_wr = 1;
		@(negedge clock);
		reg_wr = 0;
	endtask
	task rd(input [19:0] a, input [7:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1;
		@(negedge clock);
		reg_rd = 0;
		`CHK("reg_rdata", e, reg_rdata)
	endtask
	task wb(input ch, input e);
		int n;
		hit = 0;
		n = 0;
		repeat (6)
		begin
			@(negedge clock);
			hit = hit | (ch ? xfer_busy1 : xfer_busy0);
			n = n + cpu_stall;
		end
		`CHK("xfer_busy", e, hit)
		`CHK("cpu_stall_cycles", (e ? 2 : 0), n)
	endtask
	task fire(input [3:0] k);
		@(negedge clock);
		idx <= k;
		go <= 1;
		@(negedge clock);
		go <= 0;
	endtask
	task ld(input [9:0] c, input [15:0] r);
		@(negedge clock);
		count_load0 = c;
		ram_load0 = r;
		ld_wr = 1;
		@(negedge clock);
		ld_wr = 0;
	endtask
	task stop_test;
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clock);
		bad_count++;
		stop_test;
	end
	initial
	begin
		repeat (3) @(posedge clock);
		@(negedge clock);
		srst = 0;
		for (int a = 0; a < 5; a++) rd(20'hFFFBA + 20'(a), 8'h00);
		wr(`DMC_ADDR_RUN0, 8'h80, 8'hFF);
		ld(10'h002, 16'h0200);
		wr(`DMC_ADDR_MODE0, 8'h60, 8'hFF);
		wr(`DMC_ADDR_RUN0, 8'h01, 8'h01);
		rd(`DMC_ADDR_RUN0, 8'h81);
		fire(4'hA);
		wb(0, 0);
		wr(`DMC_ADDR_MODE0, 8'h80, 8'h80);
		wb(0, 1);
		`CHK("direction0", 1'b1, direction0)
		`CHK("halfword0", 1'b1, halfword0)
		`CHK("xfer_periph_addr0", 8'h10, xfer_periph_addr0)
		`CHK("xfer_ram_addr0", 16'h0200, xfer_ram_addr0)
		rd(`DMC_ADDR_MODE0, 8'h60);
		wr(`DMC_ADDR_MODE0, 8'h80, 8'h80);
		wb(0, 1);
		repeat (3) @(negedge clock);
		`CHK("transfer_counter0", 10'h000, transfer_counter0)
		`CHK("ram_address_reg0", 16'h0204, ram_address_reg0)
		`CHK("completion_irq0", 1, irq_cnt - irq_base)
		rd(`DMC_ADDR_RUN0, 8'h80);
		for (int i = 0; i < 11; i++)
		begin
			irq_base = irq_cnt;
			ld(10'h001, 16'h0300);
			wr(`DMC_ADDR_MODE0, 8'(i + 2), 8'hFF);
			wr(`DMC_ADDR_RUN0, 8'h81, 8'hFF);
			fire(4'((i + 1) % 11));
			wb(0, 0);
			fire(4'(i));
			wb(0, 1);
			repeat (2) @(negedge clock);
			`CHK("completion_irq0", 1, irq_cnt - irq_base)
			rd(`DMC_ADDR_RUN0, 8'h80);
		end
		irq_base = irq_cnt;
		ld(10'h005, 16'h0100);
		wr(`DMC_ADDR_MODE0, 8'h10, 8'hFF);
		wr(`DMC_ADDR_RUN0, 8'h81, 8'hFF);
		wr(`DMC_ADDR_MODE0, 8'h80, 8'h80);
		wb(0, 0);
		wr(`DMC_ADDR_MODE0, 8'h00, 8'h10);
		wb(0, 1);
		`CHK("direction0", 1'b0, direction0)
		`CHK("halfword0", 1'b0, halfword0)
		`CHK("xfer_periph_addr0", 8'h11, xfer_periph_addr0)
		`CHK("xfer_ram_addr0", 16'h0100, xfer_ram_addr0)
		wr(`DMC_ADDR_RUN0, 8'h80, 8'hFF);
		repeat (2) @(negedge clock);
		rd(`DMC_ADDR_RUN0, 8'h80);
		`CHK("transfer_counter0", 10'h004, transfer_counter0)
		`CHK("ram_address_reg0", 16'h0101, ram_address_reg0)
		`CHK("completion_irq0", 0, irq_cnt - irq_base)
		wr(`DMC_ADDR_RUN0, 8'h7E, 8'hFF);
		rd(`DMC_ADDR_RUN0, 8'h00);
		wr(`DMC_ADDR_MODE0, 8'h80, 8'h80);
		wb(0, 0);
		wr(`DMC_ADDR_RUN0, 8'h81, 8'hFF);
		wb(0, 0);
		wr(`DMC_ADDR_RUN1, 8'h80, 8'hFF);
		ld(10'h001, 16'h0400);
		wr(`DMC_ADDR_MODE1, 8'h4C, 8'hFF);
		wr(`DMC_ADDR_RUN1, 8'h81, 8'hFF);
		fire(4'hA);
		wb(1, 1);
		`CHK("direction1", 1'b1, direction1)
		`CHK("halfword1", 1'b0, halfword1)
		`CHK("ram_address_reg1", 16'h0401, ram_address_reg1)
		`CHK("transfer_counter1", 10'h000, transfer_counter1)
		`CHK("completion_irq1", 1, irq1_cnt)
		rd(`DMC_ADDR_RUN1, 8'h80);
		stop_test;
	end
endmodule
